// ### logic/acr_axis.sv
/*
  one acceleration axis: live 12-bit result, high-byte shadow lock and new-data flag.
  assumes read strobes are one-cycle pulses, at most one of them per cycle.
*/
`timescale 1ns/100ps
module acr_axis (
  input  wire logic        core_clk,   // core clock
  input  wire logic        rst_n,      // synchronous reset, active low
  input  wire logic        sample_vld, // new result strobe
  input  wire logic [11:0] sample,     // two's-complement result
  input  wire logic        rd_low,     // host reads low byte
  input  wire logic        rd_high,    // host reads high byte
  input  wire logic        shadow_dis, // 1 disables high-byte lock
  input  wire logic [1:0]  noise,      // filler for don't-care bits
  output logic      [7:0]  low_byte,   // low byte view
  output logic      [7:0]  high_byte,  // high byte view
  output logic             new_data    // refreshed since last read
);

  logic [11:0] res_q;
  logic [11:0] res_d;
  logic [7:0]  hold_q;
  logic        lock_q;
  logic        new_q;
  wire         take_lock = rd_low && !shadow_dis;

  // the live result keeps updating under a lock; only the view is frozen
  assign res_d     = sample_vld ? sample : res_q;
  assign low_byte  = {res_q[3:0], noise, 1'b0, new_q};          // RL5 RL7
  assign high_byte = lock_q ? hold_q : res_q[11:4];              // RL1 RL2 RL8
  assign new_data  = new_q;

  // result store
  always_ff @(posedge core_clk) begin
    if (!rst_n) res_q <= 12'h000;
    else        res_q <= res_d;
  end

  // shadow lock: low read freezes the high byte until it is read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
      hold_q <= acr_pkg::RESET_BYTE;
    end else if (rd_high) begin
      lock_q <= 1'b0;                                            // RL1 RL2
    end else if (take_lock) begin
      lock_q <= 1'b1;                                            // RL1 RL2
      hold_q <= res_q[11:4];
    end
  end

  // new-data flag; a sample in the read cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (!rst_n)                new_q <= 1'b0;
    else if (sample_vld)       new_q <= 1'b1;                     // RL16
    else if (rd_low || rd_high) new_q <= 1'b0;                   // RL16
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_lock_take;
    rd_low && !shadow_dis && !rd_high;
  endsequence

  a_lock_capture: assert property (s_lock_take |=> lock_q && high_byte == $past(res_q[11:4])) // RL1
    else $error("high byte not frozen after low read");
  a_lock_stable: assert property (s_lock_take ##1 !rd_high && !rd_low |=> $stable(high_byte)) // RL2
    else $error("locked high byte changed before its read");
  a_shadow_off: assert property (shadow_dis && !lock_q |-> high_byte == res_q[11:4]) // RL8
    else $error("high byte not live with shadowing off");
  a_new_set: assert property (sample_vld |=> new_data && low_byte[0]) // RL7
    else $error("new data flag not set by sample");
  a_new_clear: assert property ((rd_low || rd_high) && !sample_vld |=> !new_data) // RL16
    else $error("new data flag not cleared by read");
  a_low_zero: assert property (low_byte[1] == 1'b0 && low_byte[7:4] == res_q[3:0]) // RL5
    else $error("low byte layout wrong");

endmodule : acr_axis

// ### logic/acr_pkg.sv
/*
  constants for the accelerometer y/z, die temperature and motion flag readout block.
  assumes a single core clock at 25 mhz and byte-wide register reads from the host port.
*/
package acr_pkg;

  // register addresses on the host read port
  localparam logic [7:0] ADDR_Y_LOW  = 8'h04;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h05;
  localparam logic [7:0] ADDR_Z_LOW  = 8'h06;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h07;
  localparam logic [7:0] ADDR_TEMP   = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h09;

  // answer for an address outside the block and value of every register after reset
  localparam logic [7:0] READ_EMPTY  = 8'h00;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // die temperature that reads as zero, in degrees celsius
  localparam logic [7:0] TEMP_ZERO_C = 8'h18;

  // flag positions in the motion event register
  localparam int FLAG_FLAT   = 7;
  localparam int FLAG_ORIENT = 6;
  localparam int FLAG_STAP   = 5;
  localparam int FLAG_DTAP   = 4;
  localparam int FLAG_SLOW   = 3;
  localparam int FLAG_SLOPE  = 2;
  localparam int FLAG_HIGH   = 1;
  localparam int FLAG_LOW    = 0;

  // latch control codes with a fixed meaning
  localparam logic [3:0] LATCH_CODE_NONE_A = 4'h0;
  localparam logic [3:0] LATCH_CODE_NONE_B = 4'h8;
  localparam logic [3:0] LATCH_CODE_PERM_A = 4'h7;
  localparam logic [3:0] LATCH_CODE_PERM_B = 4'hF;

  // hold time for temporarily latched flags and its cycle count at 40 ns
  localparam int TEMP_HOLD_MS  = 250;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TEMP_HOLD_CYC = (TEMP_HOLD_MS * 1000000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LATCH_NONE = 2'b00,
    LATCH_TEMP = 2'b01,
    LATCH_PERM = 2'b10
  } acr_latch_t;

endpackage : acr_pkg

// ### logic/acr_readout.sv
/*
  read-only result bank: y/z acceleration, die temperature, motion event flags.
  assumes sensor, temperature and interrupt engines run on core_clk; no synchronisers needed.
*/
// Function
// [RL1] low y read with shadowing on freezes high y until it is read
// [RL2] low z read with shadowing on freezes high z until it is read
// [RL3] host reads low byte before high byte for a consistent sample
// [RL4] host avoids reads during power-up and deepest suspend
// [RL5] low byte: result bits 3..0 in 7..4, bit 1 zero, bits 3..2 random
// [RL6] host ignores bits 3 and 2 of low bytes
// [RL7] low byte bit 0 shows result refreshed since last readout
// [RL8] high byte holds result bits 11..4; result is two's complement
// [RL9] temperature register reports die temperature as signed byte
// [RL10] temperature zero means 24 degrees celsius
// [RL11] flag order 7..0: flat, orient, single tap, double tap, slow, slope, high, low
// [RL12] each flag sets when its enabled engine triggers
// [RL13] latch control selects permanent, temporary or no holding of flags
// [RL14] host enables a function before relying on its flag
// [RL15] all registers here are read-only
// [RL16] new-data flag clears on read and sets on next update
`timescale 1ns/100ps
module acr_readout #(
  parameter int HOLD_CYCLES = acr_pkg::TEMP_HOLD_CYC  // temporary latch time in cycles
) (
  input  wire logic        core_clk,     // 25 mhz core clock
  input  wire logic        rst_n,        // synchronous reset, active low
  input  wire logic        rd_en,        // host register read strobe
  input  wire logic [7:0]  rd_addr,      // host register address
  output logic      [7:0]  rd_data,      // read answer, registered
  output logic             rd_valid,     // answer valid, one cycle
  input  wire logic        shadow_dis,   // disables high-byte locking
  input  wire logic [3:0]  latch_int,    // latch control setting
  input  wire logic        int_clear,    // clears held flags
  input  wire logic        y_vld,        // y result strobe
  input  wire logic [11:0] y_sample,     // y result
  input  wire logic        z_vld,        // z result strobe
  input  wire logic [11:0] z_sample,     // z result
  input  wire logic        temp_vld,     // temperature strobe
  input  wire logic [7:0]  temp_c,       // signed die temperature, degrees
  input  wire logic [7:0]  int_en,       // per-function enables
  input  wire logic [7:0]  engine_evt,   // engine trigger levels
  output logic      [7:0]  status_flags  // motion event flags
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LD = CW'(HOLD_CYCLES);

  logic [7:0] temp_q;
  logic [7:0] flags_q;
  logic [7:0] rd_data_q;
  logic       rd_valid_q;
  logic [1:0] noise_q;
  logic [7:0] y_low, y_high, z_low, z_high;
  logic       y_new, z_new;
  acr_pkg::acr_latch_t mode;

  // address decode; writes have no path in, so every register is read-only
  wire sel_yl = rd_en && rd_addr == acr_pkg::ADDR_Y_LOW;           // RL15
  wire sel_yh = rd_en && rd_addr == acr_pkg::ADDR_Y_HIGH;
  wire sel_zl = rd_en && rd_addr == acr_pkg::ADDR_Z_LOW;
  wire sel_zh = rd_en && rd_addr == acr_pkg::ADDR_Z_HIGH;
  wire sel_tp = rd_en && rd_addr == acr_pkg::ADDR_TEMP;
  wire sel_fl = rd_en && rd_addr == acr_pkg::ADDR_FLAGS;
  wire [7:0] rd_mux = sel_yl ? y_low  :
                      sel_yh ? y_high :
                      sel_zl ? z_low  :
                      sel_zh ? z_high :
                      sel_tp ? temp_q :
                      sel_fl ? flags_q : acr_pkg::READ_EMPTY;
  wire [7:0] trig = int_en & engine_evt;                           // RL12

  // latch setting decode
  assign mode = (latch_int == acr_pkg::LATCH_CODE_NONE_A ||
                 latch_int == acr_pkg::LATCH_CODE_NONE_B) ? acr_pkg::LATCH_NONE :
                (latch_int == acr_pkg::LATCH_CODE_PERM_A ||
                 latch_int == acr_pkg::LATCH_CODE_PERM_B) ? acr_pkg::LATCH_PERM :
                                                            acr_pkg::LATCH_TEMP; // RL13

  assign rd_data      = rd_data_q;
  assign rd_valid     = rd_valid_q;
  assign status_flags = flags_q;                                   // RL11

  acr_axis u_axis_y (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .sample_vld (y_vld),
    .sample     (y_sample),
    .rd_low     (sel_yl),
    .rd_high    (sel_yh),
    .shadow_dis (shadow_dis),
    .noise      (noise_q),
    .low_byte   (y_low),
    .high_byte  (y_high),
    .new_data   (y_new)
  );

  acr_axis u_axis_z (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .sample_vld (z_vld),
    .sample     (z_sample),
    .rd_low     (sel_zl),
    .rd_high    (sel_zh),
    .shadow_dis (shadow_dis),
    .noise      (noise_q),
    .low_byte   (z_low),
    .high_byte  (z_high),
    .new_data   (z_new)
  );

  // read answer one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_q  <= acr_pkg::RESET_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_mux;
      rd_valid_q <= rd_en;
    end
  end

  // free-running filler for the don't-care low-byte bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) noise_q <= 2'b00;
    else        noise_q <= noise_q + 2'b01;                        // RL5
  end

  // temperature store, offset so that zero reads at 24 degrees
  always_ff @(posedge core_clk) begin
    if (!rst_n)        temp_q <= acr_pkg::RESET_BYTE;
    else if (temp_vld) temp_q <= temp_c - acr_pkg::TEMP_ZERO_C;   // RL9 RL10
  end

  // one latch slice per flag; a trigger always wins over a clear or a timeout
  for (genvar i = 0; i < 8; i++) begin : g_flag
    logic [CW-1:0] cnt_q;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        flags_q[i] <= 1'b0;
        cnt_q      <= '0;
      end else if (trig[i]) begin
        flags_q[i] <= 1'b1;                                        // RL12
        cnt_q      <= HOLD_LD;
      end else begin
        case (mode)
          acr_pkg::LATCH_NONE: begin
            flags_q[i] <= 1'b0;                                    // RL13
            cnt_q      <= '0;
          end
          acr_pkg::LATCH_PERM: begin
            if (int_clear) flags_q[i] <= 1'b0;                     // RL13
          end
          default: begin
            if (int_clear || cnt_q <= CW'(1)) flags_q[i] <= 1'b0;  // RL13
            if (cnt_q != '0) cnt_q <= cnt_q - CW'(1);
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_temp_offset: assert property (temp_vld |=> temp_q == $past(temp_c) - 8'h18) // RL10
    else $error("temperature offset wrong");
  a_temp_read: assert property (sel_tp && !temp_vld |=> rd_valid && rd_data == temp_q) // RL9
    else $error("temperature read wrong");
  a_unmapped_zero: assert property (rd_en && (rd_addr < 8'h04 || rd_addr > 8'h09)
                                    |=> rd_data == 8'h00) // RL15
    else $error("unmapped address not zero");
  a_flag_set: assert property (trig != 8'h00 |=> (status_flags & $past(trig)) == $past(trig)) // RL12
    else $error("triggered flag not set");
  a_none_follow: assert property (mode == acr_pkg::LATCH_NONE |=> status_flags == $past(trig)) // RL13
    else $error("unlatched flag not following engine");
  a_perm_hold: assert property (mode == acr_pkg::LATCH_PERM && !int_clear
                                |=> (status_flags & $past(flags_q)) == $past(flags_q)) // RL13
    else $error("permanently latched flag dropped");
  a_y_new_read: assert property (sel_yl |=> rd_data[0] == $past(y_new) && rd_data[1] == 1'b0) // RL7
    else $error("y new data bit wrong in read");
  a_z_new_read: assert property (sel_zl |=> rd_data[0] == $past(z_new)) // RL7
    else $error("z new data bit wrong in read");

  // read port: every strobe answers exactly one cycle later, an idle cycle answers empty
  sequence s_read_req;
    rd_en;
  endsequence

  a_read_answer: assert property (s_read_req |=> rd_valid) // RL15
    else $error("read strobe without answer");
  a_read_idle: assert property (!rd_en |=> !rd_valid && rd_data == acr_pkg::READ_EMPTY) // RL15
    else $error("answer without read strobe");

  // flag positions: only the two outer bits are checked; the six bits between them are not
  a_flat_bit: assert property (trig[acr_pkg::FLAG_FLAT] |=> // RL11
                               status_flags[acr_pkg::FLAG_FLAT])
    else $error("flat flag in wrong position");
  a_low_bit: assert property (trig[acr_pkg::FLAG_LOW] |=> // RL11
                              status_flags[acr_pkg::FLAG_LOW])
    else $error("low-g flag in wrong position");

  // a clear drops every flag that is not retriggered in the same cycle
  a_clear_drop: assert property (int_clear |=> (status_flags & ~$past(trig)) == 8'h00) // RL13
    else $error("flag survived a clear");

  // temporary latch: a fresh trigger survives a quiet cycle; needs a hold of two cycles or more
  sequence s_temp_fire;
    mode == acr_pkg::LATCH_TEMP && trig != 8'h00;
  endsequence

  sequence s_temp_quiet;
    mode == acr_pkg::LATCH_TEMP && !int_clear;
  endsequence

  a_temp_hold: assert property (s_temp_fire ##1 s_temp_quiet |=> // RL13
                                (status_flags & $past(trig, 2)) == $past(trig, 2))
    else $error("temporarily latched flag dropped early");

  // low then high read of one axis: the high answer is the result as it stood at the low read
  sequence s_y_lock;
    sel_yl && !shadow_dis;
  endsequence

  sequence s_y_release;
    !sel_yl ##1 sel_yh;
  endsequence

  sequence s_z_lock;
    sel_zl && !shadow_dis;
  endsequence

  sequence s_z_release;
    !sel_zl ##1 sel_zh;
  endsequence

  a_y_pair: assert property (s_y_lock ##1 s_y_release |=> // RL1
                             rd_data == $past(u_axis_y.res_q[11:4], 3))
    else $error("y high byte not the value locked at the low read");
  a_z_pair: assert property (s_z_lock ##1 s_z_release |=> // RL2
                             rd_data == $past(u_axis_z.res_q[11:4], 3))
    else $error("z high byte not the value locked at the low read");

endmodule : acr_readout

// ### testbench/acr_host_model.sv
/*
  host side of the register read port: issues single reads and collects the answers.
  assumes the read port answers one cycle after the strobe, with inputs moved at falling edges.
*/
`timescale 1ns/100ps
module acr_host_model (
  input  wire logic       core_clk, // core clock
  input  wire logic       rst_n,    // reset, active low
  output logic            rd_en,    // read strobe
  output logic      [7:0] rd_addr,  // read address
  input  wire logic [7:0] rd_data,  // read answer
  input  wire logic       rd_valid  // answer valid
);
  // idle port: strobe low, address parked
  initial begin
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end

  // one read; no strobe while reset is applied, and a bounded wait for the answer
  task automatic host_read(input logic [7:0] addr, output logic [7:0] data, output bit ok);
    ok   = 1'b0;
    data = 8'h00;
    for (int n = 0; n < 8 && rst_n !== 1'b1; n++) @(negedge core_clk);
    if (rst_n !== 1'b1) return;
    @(negedge core_clk);
    rd_en   = 1'b1;
    rd_addr = addr;
    @(negedge core_clk);
    rd_en   = 1'b0;
    rd_addr = ~addr; // a released address must not keep its last value
    // the answer stands between the two rising edges after the strobe: look first, then wait
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        data = rd_data;
        ok   = 1'b1;
      end else begin
        @(negedge core_clk);
      end
    end
  endtask : host_read
endmodule : acr_host_model

// ### testbench/tb_acr_readout.sv
/*
  self-checking bench for acr_readout: register reads through the host model.
  assumes acr_pkg and acr_host_model are compiled first; short hold time of 8 cycles.
*/
`timescale 1ns/100ps
module tb_acr_readout;
  logic        core_clk, rst_n, rd_en, rd_valid, shadow_dis, int_clear, y_vld, z_vld, temp_vld;
  logic [7:0]  rd_addr, rd_data, temp_c, int_en, engine_evt, status_flags;
  logic [3:0]  latch_int;
  logic [11:0] y_sample, z_sample;
  int          err_count, comparisons;
  logic [3:0]  codes [5] = '{4'h0, 4'h8, 4'h7, 4'hF, 4'h3};
  int          kinds [5] = '{0, 0, 1, 1, 2};
  logic [7:0]  temps [3] = '{8'h18, 8'h0A, 8'h64};

  acr_readout #(.HOLD_CYCLES(8)) uut (.core_clk(core_clk), .rst_n(rst_n), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .shadow_dis(shadow_dis),
    .latch_int(latch_int), .int_clear(int_clear), .y_vld(y_vld), .y_sample(y_sample),
    .z_vld(z_vld), .z_sample(z_sample), .temp_vld(temp_vld), .temp_c(temp_c),
    .int_en(int_en), .engine_evt(engine_evt), .status_flags(status_flags));

  acr_host_model host (.core_clk(core_clk), .rst_n(rst_n), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

  // 25 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  // masked read compare; a lost answer ends the run
  task automatic rd(input logic [7:0] addr, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    host.host_read(addr, d, ok);
    if (!ok) begin
      $display("Error read answer expected valid seen none");
      err_count++;
      results();
    end
    chk($sformatf("reg %h", addr), exp & mask, d & mask);
  endtask : rd

  task automatic smp(input bit z, input logic [11:0] v);
    @(negedge core_clk);
    z_vld    = z;
    y_vld    = !z;
    y_sample = v;
    z_sample = v;
    @(negedge core_clk);
    y_vld = 1'b0;
    z_vld = 1'b0;
  endtask : smp

  task automatic trig(input logic [7:0] bits);
    @(negedge core_clk);
    engine_evt = bits;
    @(negedge core_clk);
    engine_evt = 8'h00;
  endtask : trig

  // with sd clear a low read locks the high byte and a later sample must not show until the high read; with sd set it shows at once
  task automatic axis(input bit z, input bit sd);
    logic [7:0] lo;
    lo         = z ? acr_pkg::ADDR_Z_LOW : acr_pkg::ADDR_Y_LOW;
    shadow_dis = sd;
    smp(z, 12'hABC);
    rd(lo, 8'hF3, 8'hC1);
    smp(z, 12'h5E7);
    rd(lo + 8'h01, 8'hFF, sd ? 8'h5E : 8'hAB);
    rd(lo, 8'hF3, 8'h70);
    rd(lo + 8'h01, 8'hFF, 8'h5E);
  endtask : axis

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  initial begin
    {rst_n, shadow_dis, int_clear, y_vld, z_vld, temp_vld, latch_int} = '0;
    {temp_c, engine_evt, y_sample, z_sample} = '0;
    int_en      = 8'hFF;
    err_count   = 0;
    comparisons = 0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    for (int a = 4; a < 10; a++) rd(8'(a), 8'hF3, acr_pkg::RESET_BYTE);
    chk("status_flags", 8'h00, status_flags);
    $display("test reset done");
    for (int s = 0; s < 2; s++) for (int z = 0; z < 2; z++) axis(z[0], s[0]);
    $display("test axes done");
    for (int i = 0; i < 8; i++) begin
      trig(8'h01 << i);
      chk("status_flags", 8'h01 << i, status_flags);
    end
    int_en = 8'h00;
    trig(8'hFF);
    chk("status_flags", 8'h00, status_flags);
    int_en = 8'hFF;
    // five latch codes: none codes drop the flag at once, permanent codes hold it, temporary code 3 for 8 cycles; cleared on request
    for (int k = 0; k < 5; k++) begin
      latch_int = codes[k];
      trig(8'h24);
      chk("status_flags", 8'h24, status_flags);
      rd(acr_pkg::ADDR_FLAGS, 8'hFF, kinds[k] != 0 ? 8'h24 : 8'h00);
      repeat (12) @(negedge core_clk);
      chk("status_flags", kinds[k] == 1 ? 8'h24 : 8'h00, status_flags);
      int_clear = 1'b1;
      @(negedge core_clk);
      int_clear = 1'b0;
      chk("status_flags", 8'h00, status_flags);
    end
    $display("test flags done");
    foreach (temps[t]) begin
      @(negedge core_clk);
      temp_c   = temps[t];
      temp_vld = 1'b1;
      @(negedge core_clk);
      temp_vld = 1'b0;
      rd(acr_pkg::ADDR_TEMP, 8'hFF, temps[t] - acr_pkg::TEMP_ZERO_C);
    end
    $display("test temperature done");
    rd(8'h0A, 8'hFF, acr_pkg::READ_EMPTY);
    rd(8'h03, 8'hFF, acr_pkg::READ_EMPTY);
    $display("test unmapped done");
    results();
  end
endmodule : tb_acr_readout
